// ===== core/microcoded_opcode_sequencer.v
`timescale 1ns/100ps
`include "seq_consts.vh"

// Function
// RULE1 - instructions run as microcode states, one per four clocks
// RULE2 - one state per four input clocks
// RULE3 - state counts are minimum; waits extend
// RULE4 - waits stretch only external access states
// RULE5 - operand bytes fetched in ascending address
// RULE6 - register/peripheral moves map reversed operand order
// RULE7 - accumulator and index consume no bytes
// RULE8 - opcode then up to three ordered operands
// RULE9 - decode instruction types from opcode values
// RULE10 - F4 prefix gives offset plus pair
// RULE11 - add-with-carry opcode group decode
// RULE12 - plain add opcode group decode
// RULE13 - logical and opcodes plus peripheral forms
// RULE14 - branch absolute, indexed, indirect, offset forms
// RULE15 - bit test jump one and zero
// RULE16 - single-bit jumps reuse bit test opcodes
// RULE17 - relative conditional jump opcodes
// RULE18 - F0 operand sets interrupt enables
// RULE19 - idle F6; increment B3 C3 D3
// RULE20 - fixed state list per opcode
// RULE21 - waits in internal states held pending
module microcoded_opcode_sequencer (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// program memory and peripheral bus
	input  wire [7:0]  mem_rdata,
	input  wire        wait_pin,
	input  wire        autowait_en,
	input  wire        periph_autowait_en,
	// datapath feedback
	input  wire        take_jump,
	input  wire [15:0] pair_value,
	input  wire [7:0]  index_value,
	input  wire        idle_wake,
	// bus side
	output reg  [15:0] mem_addr_r,
	output reg         fetch_r,
	// datapath control
	output reg  [4:0]  uop_r,
	output reg         state_tick_r,
	output reg         stretch_r,
	output reg         instr_done_r,
	output reg  [7:0]  opcode_r,
	output reg         prefix_r,
	output reg  [6:0]  itype_r,
	output reg  [7:0]  src_byte_r,
	output reg  [7:0]  dst_byte_r,
	output reg  [7:0]  opnd3_r,
	output reg         idle_r,
	output reg         irq_high_en_r,
	output reg         irq_low_en_r
);

	localparam [79:0] SEQ_FETCH = {`U_OC, `U_CT, {14{`U_NO}}};
	localparam [79:0] SEQ_PFX   = {`U_PF, `U_CT, `U_OC, `U_CT, {12{`U_NO}}};

	reg [1:0]  phase_r;
	reg [79:0] seq_r;
	reg [3:0]  idx_r;
	reg [15:0] pc_r;
	reg [7:0]  opnd1_r, opnd2_r, last_r;
	reg        wait_pend_r, auto_done_r;

	reg [79:0] seq_nxt;
	reg [3:0]  idx_nxt;
	reg [15:0] pc_nxt;
	reg [7:0]  opnd1_nxt, opnd2_nxt, opnd3_nxt, last_nxt, opcode_nxt;
	reg [6:0]  itype_nxt;
	reg        pfx_nxt, wait_pend_nxt, auto_done_nxt, idle_nxt, irq_high_nxt, irq_low_nxt;
	reg        done_nxt, tick, stretch, auto_need;
	reg [4:0]  cur, prev, nxt_op, uop_nxt;

	function [4:0] slot;
		input [79:0] s;
		input [3:0]  i;
		begin
			slot = s[(79 - 5 * i) -: 5];
		end
	endfunction

	function is_fetch;
		input [4:0] u;
		begin
			is_fetch = (u == `U_OC) || (u == `U_O1) || (u == `U_O2) || (u == `U_O3)
				|| (u == `U_PF);
		end
	endfunction

	// per-opcode state lists; A and B states access implied registers, no bytes
	function [79:0] useq;
		input       pfx;
		input [7:0] op;
		reg   [3:0] hi;
		reg   [4:0] xr;
		reg   [4:0] xw;
		begin
			hi = op[7:4];
			xr = (hi == 4'h3 || hi == 4'h5 || hi == 4'h9 || hi == 4'hc) ? `U_BRD : `U_ARD; // RULE7
			xw = (hi == 4'h3 || hi == 4'h5 || hi == 4'hc) ? `U_BWR : `U_AWR;
			useq = {`U_OC, `U_CT, `U_IC, {13{`U_NO}}};
			if (pfx) begin
				if (op == `OP_OFS_BRANCH)
					useq = {`U_PF, `U_CT, `U_OC, `U_CT, `U_IC, `U_IC, `U_O1, `U_CT, `U_O2,
						`U_CT, `U_RRD, `U_RRD, `U_IC, `U_IC, `U_IC, `U_IC}; // RULE10
			end else if ((op[3:0] == 4'h9 || op[3:0] == 4'h8 || op[3:0] == 4'h3)
				&& hi >= 4'h1 && hi <= 4'h7) begin // RULE11 RULE12 RULE13
				case (hi)
					4'h6: useq = {`U_OC, `U_CT, `U_PO, `U_CT, `U_BRD, `U_IC, `U_ARD, `U_AWR,
						{8{`U_NO}}};
					4'h1, 4'h3: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, xr, xw, {9{`U_NO}}};
					4'h2, 4'h5: useq = {`U_OC, `U_CT, `U_O1, `U_CT, xr, xw, {10{`U_NO}}};
					4'h4: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, `U_O2, `U_CT, `U_RRD,
						`U_RWR, {7{`U_NO}}};
					default: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_RRD, `U_RWR,
						{8{`U_NO}}};
				endcase
			end else if ((op[3:0] == 4'h6 || op[3:0] == 4'h7) && hi >= 4'h1 && hi <= 4'ha) begin
				case (hi) // RULE15 RULE16
					4'h2, 4'h5: useq = {`U_OC, `U_CT, `U_O1, `U_CT, xr, `U_IC, `U_O2, `U_CT,
						`U_RJ, `U_RJ, {6{`U_NO}}};
					4'ha: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_PRD, `U_CT,
						`U_IC, `U_O3, `U_CT, `U_RJ, `U_RJ, {3{`U_NO}}};
					4'h7: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_RRD, `U_IC,
						`U_O3, `U_CT, `U_RJ, `U_RJ, {4{`U_NO}}};
					4'h8, 4'h9: useq = {`U_OC, `U_CT, `U_O1, `U_CT, xr, `U_PRD, `U_CT, `U_IC,
						`U_O2, `U_CT, `U_RJ, `U_RJ, {4{`U_NO}}};
					4'h6: useq = {`U_OC, `U_CT, `U_PO, `U_CT, `U_BRD, `U_IC, `U_ARD, `U_IC,
						`U_O1, `U_CT, `U_RJ, `U_RJ, {4{`U_NO}}};
					4'h1, 4'h3: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, xr, `U_IC, `U_O2,
						`U_CT, `U_RJ, `U_RJ, {5{`U_NO}}};
					default: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, `U_O2, `U_CT, `U_RRD,
						`U_IC, `U_O3, `U_CT, `U_RJ, `U_RJ, {3{`U_NO}}};
				endcase
			end else begin
				case (op)
					8'h83, 8'h93: useq = {`U_OC, `U_CT, `U_O1, `U_CT, xr, `U_PRD, `U_CT,
						`U_PWR, `U_CT, {7{`U_NO}}};
					8'ha3: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_PRD, `U_CT,
						`U_PWR, `U_CT, {6{`U_NO}}};
					8'h8c: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_IC, `U_IC,
						`U_IC, {7{`U_NO}}}; // RULE14
					8'hac: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_BRD, `U_IC,
						`U_IC, `U_IC, `U_IC, {5{`U_NO}}};
					8'h9c: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, `U_RRD, `U_IC, `U_IC,
						{8{`U_NO}}};
					8'h00: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_IC, `U_RJ, `U_RJ,
						{9{`U_NO}}};
					8'h02, 8'h03, 8'h0b, 8'h0d, 8'h0e:
						useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RJ, {11{`U_NO}}}; // RULE17
					`OP_IRQ_ENABLE: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_IC, `U_IC,
						{10{`U_NO}}};
					`OP_IDLE: useq = {`U_OC, `U_CT, `U_IC, `U_IC, `U_IC, `U_IC, {10{`U_NO}}};
					8'hb3, 8'hc3: useq = {`U_OC, `U_CT, `U_PO, `U_CT, xr, xw, `U_IC, `U_IC,
						{8{`U_NO}}}; // RULE19
					8'hd3: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_RRD, `U_RWR, {10{`U_NO}}};
					`OP_MOV_R_P: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_RRD,
						`U_CT, `U_PWR, `U_CT, {6{`U_NO}}};
					`OP_MOV_P_R: useq = {`U_OC, `U_CT, `U_O1, `U_CT, `U_O2, `U_CT, `U_PRD,
						`U_CT, `U_IC, `U_RWR, {6{`U_NO}}};
					default: useq = {`U_OC, `U_CT, `U_IC, {13{`U_NO}}};
				endcase
			end
		end
	endfunction

	function [6:0] itype;
		input       pfx;
		input [7:0] op;
		reg   [3:0] hi;
		begin
			hi = op[7:4];
			itype = `T_UNKNOWN;
			if (pfx)
				itype = (op == `OP_OFS_BRANCH) ? `T_BR : `T_UNKNOWN;
			else if (op[3:0] == 4'h9 && hi >= 4'h1 && hi <= 4'h7)
				itype = `T_ADC; // RULE11
			else if (op[3:0] == 4'h8 && hi >= 4'h1 && hi <= 4'h7)
				itype = `T_ADD; // RULE12
			else if (op[3:0] == 4'h3 && hi >= 4'h1 && hi <= 4'ha)
				itype = `T_AND; // RULE13
			else if (op[3:0] == 4'h6 && hi >= 4'h1 && hi <= 4'ha)
				itype = `T_BIT_TEST_JUMP_ONE; // RULE15 RULE16
			else if (op[3:0] == 4'h7 && hi >= 4'h1 && hi <= 4'ha)
				itype = `T_BIT_TEST_JUMP_ZERO;
			else begin
				case (op)
					8'h8c, 8'hac, 8'h9c:     itype = `T_BR; // RULE14
					8'h00:                   itype = `T_JMP;
					8'h03:                   itype = `T_JC; // RULE17
					8'h02:                   itype = `T_JEQ;
					8'h0e:                   itype = `T_JG;
					8'h0d:                   itype = `T_JGE;
					8'h0b:                   itype = `T_JHS;
					`OP_IRQ_ENABLE:          itype = `T_IRQ_EN; // RULE18
					`OP_IDLE:                itype = `T_IDLE; // RULE19
					8'hb3, 8'hc3, 8'hd3:     itype = `T_INC;
					`OP_MOV_R_P, `OP_MOV_P_R: itype = `T_MOV;
					default:                 itype = `T_UNKNOWN;
				endcase
			end
		end
	endfunction

	always @* begin
		seq_nxt       = seq_r;
		idx_nxt       = idx_r;
		pc_nxt        = pc_r;
		opnd1_nxt     = opnd1_r;
		opnd2_nxt     = opnd2_r;
		opnd3_nxt     = opnd3_r;
		last_nxt      = last_r;
		opcode_nxt    = opcode_r;
		itype_nxt     = itype_r;
		pfx_nxt       = prefix_r;
		wait_pend_nxt = wait_pend_r;
		auto_done_nxt = auto_done_r;
		idle_nxt      = idle_r;
		irq_high_nxt  = irq_high_en_r;
		irq_low_nxt   = irq_low_en_r;
		done_nxt      = 1'b0;
		tick          = (phase_r == `LAST_PHASE); // RULE2
		cur           = slot(seq_r, idx_r);
		prev          = (idx_r == 4'h0) ? `U_NO : slot(seq_r, idx_r - 4'h1);
		nxt_op        = (idx_r == 4'hf) ? `U_NO : slot(seq_r, idx_r + 4'h1);
		auto_need     = (is_fetch(prev) && autowait_en)
			|| ((prev == `U_PRD || prev == `U_PWR) && periph_autowait_en);
		// only external continuations may stretch
		stretch       = (cur == `U_CT) && !idle_r
			&& (wait_pin || wait_pend_r || (auto_need && !auto_done_r)); // RULE3 RULE4
		if (idle_r) begin
			if (idle_wake)
				idle_nxt = 1'b0;
		end else if (tick) begin
			if (stretch) begin
				wait_pend_nxt = 1'b0; // RULE21
				if (auto_need)
					auto_done_nxt = 1'b1;
			end else begin
				auto_done_nxt = 1'b0;
				idx_nxt       = idx_r + 4'h1; // RULE1 RULE20
				if (cur == `U_CT && is_fetch(prev))
					pc_nxt = pc_r + 16'h0001; // RULE5
				if (cur == `U_CT && prev == `U_OC) begin
					if (!prefix_r && mem_rdata == `OP_PREFIX) begin
						pfx_nxt = 1'b1;
						seq_nxt = SEQ_PFX; // RULE10
					end else begin
						opcode_nxt = mem_rdata;
						itype_nxt  = itype(prefix_r, mem_rdata); // RULE9
						seq_nxt    = useq(prefix_r, mem_rdata);
						idx_nxt    = prefix_r ? 4'h4 : 4'h2;
					end
				end else begin
					if (cur == `U_CT && prev == `U_O1) begin
						opnd1_nxt = mem_rdata; // RULE8
						last_nxt  = mem_rdata;
					end
					if (cur == `U_CT && prev == `U_O2) begin
						opnd2_nxt = mem_rdata;
						last_nxt  = mem_rdata;
					end
					if (cur == `U_CT && prev == `U_O3) begin
						opnd3_nxt = mem_rdata;
						last_nxt  = mem_rdata;
					end
					if (cur == `U_RJ && prev != `U_RJ && (take_jump || itype_r == `T_JMP))
						pc_nxt = pc_r + {{8{last_r[7]}}, last_r};
					if (nxt_op == `U_NO) begin
						done_nxt = 1'b1;
						seq_nxt  = SEQ_FETCH;
						idx_nxt  = 4'h0;
						pfx_nxt  = 1'b0;
						if (itype_r == `T_BR) begin // RULE14
							if (prefix_r)
								pc_nxt = pair_value + {8'h00, opnd1_r}; // RULE10
							else if (opcode_r == 8'h8c)
								pc_nxt = {opnd1_r, opnd2_r};
							else if (opcode_r == 8'hac)
								pc_nxt = {opnd1_r, opnd2_r} + {8'h00, index_value};
							else
								pc_nxt = pair_value;
						end
						if (itype_r == `T_IRQ_EN) begin
							irq_high_nxt = opnd1_r[`IRQ_HIGH_BIT]; // RULE18
							irq_low_nxt  = opnd1_r[`IRQ_LOW_BIT];
						end
						if (itype_r == `T_IDLE)
							idle_nxt = 1'b1; // RULE19
					end
				end
			end
		end
		// a wait seen in an internal state is kept for the next continuation
		if (wait_pin && cur != `U_CT && !idle_r)
			wait_pend_nxt = 1'b1; // RULE21
		uop_nxt = slot(seq_nxt, idx_nxt);
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			phase_r       <= 2'h0;
			seq_r         <= SEQ_FETCH;
			idx_r         <= 4'h0;
			pc_r          <= `RESET_PC;
			opnd1_r       <= 8'h00;
			opnd2_r       <= 8'h00;
			last_r        <= 8'h00;
			wait_pend_r   <= 1'b0;
			auto_done_r   <= 1'b0;
			mem_addr_r    <= `RESET_PC;
			fetch_r       <= 1'b1;
			uop_r         <= `U_OC;
			state_tick_r  <= 1'b0;
			stretch_r     <= 1'b0;
			instr_done_r  <= 1'b0;
			opcode_r      <= 8'h00;
			prefix_r      <= 1'b0;
			itype_r       <= `T_UNKNOWN;
			src_byte_r    <= 8'h00;
			dst_byte_r    <= 8'h00;
			opnd3_r       <= 8'h00;
			idle_r        <= 1'b0;
			irq_high_en_r <= 1'b0;
			irq_low_en_r  <= 1'b0;
		end else begin
			phase_r       <= phase_r + 2'h1;
			seq_r         <= seq_nxt;
			idx_r         <= idx_nxt;
			pc_r          <= pc_nxt;
			opnd1_r       <= opnd1_nxt;
			opnd2_r       <= opnd2_nxt;
			last_r        <= last_nxt;
			wait_pend_r   <= wait_pend_nxt;
			auto_done_r   <= auto_done_nxt;
			mem_addr_r    <= pc_nxt;
			fetch_r       <= is_fetch(uop_nxt);
			uop_r         <= uop_nxt;
			state_tick_r  <= tick && !idle_r && !stretch;
			stretch_r     <= tick && stretch;
			instr_done_r  <= done_nxt;
			opcode_r      <= opcode_nxt;
			prefix_r      <= pfx_nxt;
			itype_r       <= itype_nxt;
			// reversed byte order for register/peripheral moves
			if (!pfx_nxt && (opcode_nxt == `OP_MOV_R_P || opcode_nxt == `OP_MOV_P_R)) begin
				src_byte_r <= opnd2_nxt; // RULE6
				dst_byte_r <= opnd1_nxt;
			end else begin
				src_byte_r <= opnd1_nxt;
				dst_byte_r <= opnd2_nxt;
			end
			opnd3_r       <= opnd3_nxt;
			idle_r        <= idle_nxt;
			irq_high_en_r <= irq_high_nxt;
			irq_low_en_r  <= irq_low_nxt;
		end
	end

endmodule // microcoded_opcode_sequencer

// ===== core/seq_consts.vh
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
// state timing: four input-clock periods per internal state
`define LAST_PHASE    2'h3
`define RESET_PC      16'h0000
// micro-op codes, one per internal state
`define U_NO          5'h00
`define U_OC          5'h01
`define U_CT          5'h02
`define U_O1          5'h03
`define U_O2          5'h04
`define U_O3          5'h05
`define U_PO          5'h06
`define U_PF          5'h07
`define U_ARD         5'h08
`define U_AWR         5'h09
`define U_BRD         5'h0a
`define U_BWR         5'h0b
`define U_RRD         5'h0c
`define U_RWR         5'h0d
`define U_PRD         5'h0e
`define U_PWR         5'h0f
`define U_IC          5'h10
`define U_RJ          5'h11
// special opcodes
`define OP_PREFIX     8'hf4
`define OP_IRQ_ENABLE 8'hf0
`define OP_IDLE       8'hf6
`define OP_OFS_BRANCH 8'hec
`define OP_MOV_R_P    8'h71
`define OP_MOV_P_R    8'ha2
// irq enable operand bit positions
`define IRQ_HIGH_BIT  2
`define IRQ_LOW_BIT   3
// instruction type codes
`define T_UNKNOWN     7'h00
`define T_ADC         7'h01
`define T_ADD         7'h02
`define T_AND         7'h03
`define T_BR          7'h04
`define T_BIT_TEST_JUMP_ONE  7'h05
`define T_BIT_TEST_JUMP_ZERO 7'h06
`define T_JMP         7'h07
`define T_JC          7'h08
`define T_JEQ         7'h09
`define T_JG          7'h0a
`define T_JGE         7'h0b
`define T_JHS         7'h0c
`define T_IRQ_EN      7'h0d
`define T_IDLE        7'h0e
`define T_INC         7'h0f
`define T_MOV         7'h10
`endif

// ===== verification/prog_mem_model.sv
`timescale 1ns/100ps
module prog_mem_model (
	// bus from the sequencer
	input  wire logic [15:0] addr,
	output wire logic [7:0]  rdata
);
	logic [7:0] mem [0:65535];
	// unloaded bytes read as an unimplemented opcode, never as unknown
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
	end
	assign rdata = mem[addr];
endmodule // prog_mem_model

// ===== verification/microcoded_opcode_sequencer_sva.sv
`timescale 1ns/100ps
`include "seq_consts.vh"
module seq_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       idle_wake,
	input wire logic [4:0] uop_r,
	input wire logic       fetch_r,
	input wire logic       state_tick_r,
	input wire logic       stretch_r,
	input wire logic       instr_done_r,
	input wire logic [7:0] opcode_r,
	input wire logic       prefix_r,
	input wire logic [6:0] itype_r,
	input wire logic       idle_r,
	input wire logic       irq_high_en_r,
	input wire logic       irq_low_en_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// idle may freeze the state clock, so it is excluded
	property p_tick; disable iff (sys_rst || idle_r)
		(state_tick_r || stretch_r) |=> !state_tick_r [*3] ##1 (state_tick_r || stretch_r);
	endproperty
	a_tick: assert property (p_tick) else $error("state spacing not four clocks");
	property p_done; instr_done_r |-> state_tick_r; endproperty
	a_done: assert property (p_done) else $error("done without state end");
	property p_str; stretch_r |-> !state_tick_r && uop_r == `U_CT; endproperty
	a_str: assert property (p_str) else $error("stretch outside access state");
	property p_fetch;
		fetch_r == (uop_r inside {`U_OC, `U_O1, `U_O2, `U_O3, `U_PF});
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch flag disagrees");
	property p_next;
		instr_done_r && !idle_r && opcode_r != `OP_IDLE |-> uop_r inside {`U_OC, `U_PF};
	endproperty
	a_next: assert property (p_next) else $error("next fetch missing");
	property p_idle; idle_r && !idle_wake |=> idle_r; endproperty
	a_idle: assert property (p_idle) else $error("idle left without wake");
	property p_irq;
		!sys_rst && $changed({irq_high_en_r, irq_low_en_r})
			|-> opcode_r == `OP_IRQ_ENABLE;
	endproperty
	a_irq: assert property (p_irq) else $error("enables moved");
	property p_adc;
		instr_done_r && !$past(prefix_r)
			&& opcode_r inside {8'h69, 8'h19, 8'h29, 8'h39, 8'h59, 8'h49, 8'h79}
			|-> itype_r == `T_ADC;
	endproperty
	a_adc: assert property (p_adc) else $error("carry add decode");
	property p_ofs;
		instr_done_r && $past(prefix_r) && opcode_r == `OP_OFS_BRANCH |-> itype_r == `T_BR;
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset branch decode");
endmodule // seq_checker
bind microcoded_opcode_sequencer seq_checker chk_u (.clk, .sys_rst, .idle_wake, .uop_r,
	.fetch_r, .state_tick_r, .stretch_r, .instr_done_r, .opcode_r, .prefix_r, .itype_r,
	.idle_r, .irq_high_en_r, .irq_low_en_r);

// ===== verification/microcoded_opcode_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "seq_consts.vh"
module microcoded_opcode_sequencer_tb_top;
	logic        clk = 0, sys_rst = 1, wait_pin = 0, autowait_en = 0;
	logic        periph_autowait_en = 0, take_jump = 0, idle_wake = 0, wr = 0;
	logic [15:0] pair_value = 0;
	logic [7:0]  index_value = 0, b1, b2, b3;
	logic [6:0]  e;
	wire  [7:0]  mem_rdata, opcode_r, src_byte_r, dst_byte_r, opnd3_r;
	wire  [15:0] mem_addr_r;
	wire  [4:0]  uop_r;
	wire  [6:0]  itype_r;
	wire         fetch_r, state_tick_r, stretch_r, instr_done_r, prefix_r;
	wire         idle_r, irq_high_en_r, irq_low_en_r;
	integer      err_count = 0, checked = 0, cyc = 0, n, m;
	logic [7:0]  iq [4] = '{8'h0c, 8'h04, 8'h08, 8'h00};

	microcoded_opcode_sequencer dut_u (.clk, .sys_rst, .mem_rdata, .wait_pin, .autowait_en,
		.periph_autowait_en, .take_jump, .pair_value, .index_value, .idle_wake, .mem_addr_r,
		.fetch_r, .uop_r, .state_tick_r, .stretch_r, .instr_done_r, .opcode_r, .prefix_r,
		.itype_r, .src_byte_r, .dst_byte_r, .opnd3_r, .idle_r, .irq_high_en_r, .irq_low_en_r);
	prog_mem_model mem_u (.addr(mem_addr_r), .rdata(mem_rdata));

	always #5 clk = ~clk;
	// about 260 short programs of under 100 cycles each
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			test_done;
		end
	end

	function automatic [7:0] rb;
		rb = $urandom;
	endfunction
	function automatic [6:0] exp_type(input [7:0] op);
		case (op)
		8'h69, 8'h19, 8'h29, 8'h39, 8'h59, 8'h49, 8'h79: exp_type = `T_ADC;
		8'h68, 8'h18, 8'h28, 8'h38, 8'h58, 8'h48, 8'h78: exp_type = `T_ADD;
		8'h63, 8'h13, 8'h23, 8'h33, 8'h53, 8'h43, 8'h73, 8'h83, 8'h93, 8'ha3: exp_type = `T_AND;
		8'h8c, 8'hac, 8'h9c: exp_type = `T_BR;
		8'ha6, 8'h66, 8'h16, 8'h26, 8'h36, 8'h56, 8'h46, 8'h76, 8'h86, 8'h96:
			exp_type = `T_BIT_TEST_JUMP_ONE;
		8'ha7, 8'h67, 8'h17, 8'h27, 8'h37, 8'h57, 8'h47, 8'h77, 8'h87, 8'h97:
			exp_type = `T_BIT_TEST_JUMP_ZERO;
		8'h00: exp_type = `T_JMP;
		8'h03: exp_type = `T_JC;
		8'h02: exp_type = `T_JEQ;
		8'h0e: exp_type = `T_JG;
		8'h0d: exp_type = `T_JGE;
		8'h0b: exp_type = `T_JHS;
		8'hf0: exp_type = `T_IRQ_EN;
		8'hf6: exp_type = `T_IDLE;
		8'hb3, 8'hc3, 8'hd3: exp_type = `T_INC;
		8'h71, 8'ha2: exp_type = `T_MOV;
		default: exp_type = `T_UNKNOWN;
		endcase
	endfunction

	task chk(input string nm, input [15:0] ex, input [15:0] got);
		checked++;
		if (got !== ex) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// random wait requests only while wr is set
	task wait_done;
		n = 0;
		do begin
			@(posedge clk);
			wait_pin <= wr & ($urandom % 8 == 0);
			#1;
			n++;
		end while (instr_done_r !== 1'b1 && n < 500);
		if (n >= 500) chk("done", 1, 0);
	endtask
	task run(input [7:0] c0, c1, c2, c3);
		mem_u.mem[0] = c0;
		mem_u.mem[1] = c1;
		mem_u.mem[2] = c2;
		mem_u.mem[3] = c3;
		@(posedge clk);
		sys_rst <= 1;
		wait_pin <= 0;
		take_jump <= $urandom;
		pair_value <= $urandom;
		index_value <= $urandom;
		periph_autowait_en <= $urandom;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		wait_done;
	endtask
	// pulse requests one wait during the opcode state of the timed instruction
	task dur(input [15:0] ex, input pulse);
		run(8'h29, rb(), 8'h29, rb());
		m = 0;
		do begin
			@(posedge clk);
			wait_pin <= pulse && m == 0;
			#1;
			m++;
		end while (instr_done_r !== 1'b1 && m < 200);
		chk("spacing", ex, m);
	endtask

	initial begin
		void'($urandom(3));
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		wr = 1;
		for (int i = 0; i < 256; i++) begin
			if (i == 8'hf4) continue;
			b1 = rb();
			b2 = rb();
			b3 = rb();
			run(i[7:0], b1, b2, b3);
			e = exp_type(i[7:0]);
			chk("itype", e, itype_r);
			chk("opcode", i[7:0], opcode_r);
			case (i[7:0])
			8'h8c: chk("pc", {b1, b2}, mem_addr_r);
			8'hac: chk("pc", {b1, b2} + index_value, mem_addr_r);
			8'h9c: chk("pc", pair_value, mem_addr_r);
			8'h00: chk("pc", 16'h2 + {{8{b1[7]}}, b1}, mem_addr_r);
			8'h71, 8'ha2: chk("pair", {b2, b1}, {src_byte_r, dst_byte_r});
			8'h79: chk("pair", {b1, b2}, {src_byte_r, dst_byte_r});
			8'hf6: chk("idle", 1, idle_r);
			8'h02, 8'h03, 8'h0b, 8'h0d, 8'h0e:
				chk("pc", 16'h2 + (take_jump ? {{8{b1[7]}}, b1} : 16'h0), mem_addr_r);
			8'h46, 8'h47, 8'h76, 8'h77, 8'ha6, 8'ha7: chk("opnd3", b3, opnd3_r);
			default: ;
			endcase
		end
		$display("test decode sweep done");
		for (int k = 0; k < 4; k++) begin
			run(8'hf0, iq[k], rb(), rb());
			chk("irq", {iq[k][`IRQ_LOW_BIT], iq[k][`IRQ_HIGH_BIT]}, {irq_low_en_r, irq_high_en_r});
		end
		$display("test interrupt enables done");
		b2 = rb();
		run(`OP_PREFIX, `OP_OFS_BRANCH, b2, rb());
		chk("pc", pair_value + b2, mem_addr_r);
		chk("itype", `T_BR, itype_r);
		$display("test offset branch done");
		run(`OP_IDLE, rb(), rb(), rb());
		repeat (8) @(posedge clk);
		#1;
		chk("idle", 1, idle_r);
		@(posedge clk);
		idle_wake <= 1;
		@(posedge clk);
		idle_wake <= 0;
		#1;
		chk("idle", 0, idle_r);
		$display("test idle wake done");
		wr = 0;
		dur(24, 0);
		dur(28, 1);
		@(posedge clk);
		autowait_en <= 1;
		dur(32, 0);
		$display("test timing done");
		test_done;
	end
endmodule // microcoded_opcode_sequencer_tb_top
